// *** inc/exc_unit_consts.svh ***
// Purpose: offsets, field positions, reset values and vector numbers
// Assumes: word-aligned 32-bit register bus, byte addresses below
// Notes:   included by the exception unit and its vector map
`ifndef EXC_UNIT_CONSTS_SVH
`define EXC_UNIT_CONSTS_SVH

// ==========================================================
// register byte offsets
`define OFS_SYS_CTRL3   8'h00
`define OFS_EXC_STATUS  8'h04
`define OFS_EXC_MASK    8'h08
`define OFS_EXC_INFO    8'h0C

// ==========================================================
// system control three layout and reset value
`define SCR3_RESET      8'h60
`define SCR3_VTS_BIT    6
`define SCR3_RMS_BIT    5
`define STAT_WIDTH      5

// ==========================================================
// vector numbers
`define VEC_RESET       7'h00
`define VEC_ILLEGAL     7'h04
`define VEC_DIRECT      7'h06
`define VEC_NMI         7'h07
`define VEC_TRAP_BASE   7'h08
`define VEC_KEY_COMPAT  7'h16
`define VEC_KEY_EXT     7'h1E

`endif

// *** inc/exc_unit_pkg.sv ***
// Purpose: types shared by the exception unit files
// Assumes: one-hot codes throughout
// Notes:   exception type bits double as status bit positions
package exc_unit_pkg;

  typedef enum logic [4:0] {
    EXC_RESET   = 5'h01,
    EXC_ILLEGAL = 5'h02,
    EXC_IRQ     = 5'h04,
    EXC_DIRECT  = 5'h08,
    EXC_TRAP    = 5'h10
  } exc_type_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'h1,
    ST_EXC = 2'h2
  } seq_state_t;

endpackage : exc_unit_pkg

// *** src/exc_priority_unit.sv ***
// Purpose: ranks exception requests, sequences their start, holds system control three
// Assumes: sequencer pulses are one cycle wide and synchronous to clk_in
// Notes:   registers on an AHB-Lite slave; reads take one wait state
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "exc_unit_consts.svh"

module exc_priority_unit (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic      [31:0] hrdata_out,
  input  wire logic        external_reset_input_in,
  input  wire logic        watchdog_overflow_in,
  input  wire logic        illegal_opcode_in,
  input  wire logic        insn_done_in,
  input  wire logic        insn_no_irq_in,
  input  wire logic        sleep_direct_in,
  input  wire logic        trap_always_instruction_in,
  input  wire logic [1:0]  trap_num_in,
  input  wire logic        exec_state_in,
  input  wire logic        exc_done_in,
  input  wire logic        nmi_in,
  input  wire logic        irq_req_in,
  input  wire logic [6:0]  irq_vec_in,
  input  wire logic [1:0]  key_input_req_in,
  input  wire logic        keypad_wakeup_bank_select_in,
  input  wire logic        serial_bus_register_enable_in,
  output logic             key_bank_lo_en_out,
  output logic             key_bank_hi_en_out,
  output logic             serial_bank_lo_en_out,
  output logic             serial_bank_hi_en_out,
  output logic             vector_table_select_out,
  output logic             register_map_select_out,
  output logic             exc_valid_out,
  output logic      [4:0]  exc_type_out,
  output logic      [6:0]  exc_vector_out,
  output logic      [31:0] exc_addr_out,
  output logic             irq_out
);

  // ==========================================================
  // bus slave
  logic                 dp_q;
  logic                 dp_wr_q;
  logic [7:0]           dp_addr_q;
  logic                 rd_ok_q;
  logic [31:0]          rdata_q;
  logic [31:0]          rd_mux;
  logic                 wr_now;
  logic [7:0]           scr3_q;
  logic [`STAT_WIDTH-1:0] stat_q;
  logic [`STAT_WIDTH-1:0] mask_q;

  // reads wait one cycle so a write just before is already visible
  assign hreadyout_out = ce_in & ~(dp_q & ~dp_wr_q & ~rd_ok_q);
  assign hresp_out     = 1'b0;
  assign hrdata_out    = rdata_q;
  assign wr_now        = ce_in & dp_q & dp_wr_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dp_q      <= 1'b0;
      dp_wr_q   <= 1'b0;
      dp_addr_q <= 8'h00;
    end else if (ce_in && hready_in) begin
      dp_q      <= hsel_in & htrans_in[1];
      dp_wr_q   <= hwrite_in;
      dp_addr_q <= haddr_in[7:0];
    end
  end

  always_comb begin
    unique case (dp_addr_q)
      `OFS_SYS_CTRL3:  rd_mux = {24'h000000, scr3_q};
      `OFS_EXC_STATUS: rd_mux = {27'h0000000, stat_q};
      `OFS_EXC_MASK:   rd_mux = {27'h0000000, mask_q};
      `OFS_EXC_INFO:   rd_mux = {19'h00000, exc_valid_out, exc_type_out, exc_vector_out};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_ok_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else if (ce_in) begin
      if (dp_q && !dp_wr_q && !rd_ok_q) begin
        rd_ok_q <= 1'b1;
        rdata_q <= rd_mux;
      end else if (hready_in) begin
        rd_ok_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // system control three
  // reset to extended
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scr3_q <= `SCR3_RESET;
    end else if (wr_now && dp_addr_q == `OFS_SYS_CTRL3) begin
      scr3_q <= hwdata_in[7:0];
    end
  end

  assign vector_table_select_out = scr3_q[`SCR3_VTS_BIT];
  assign register_map_select_out = scr3_q[`SCR3_RMS_BIT];

  assign key_bank_lo_en_out    = register_map_select_out | ~keypad_wakeup_bank_select_in;
  assign key_bank_hi_en_out    = register_map_select_out | keypad_wakeup_bank_select_in;
  assign serial_bank_lo_en_out = register_map_select_out | ~serial_bus_register_enable_in;
  assign serial_bank_hi_en_out = register_map_select_out | serial_bus_register_enable_in;

  // ==========================================================
  // request capture
  logic                    pin_q;
  logic                    rpend_q;
  logic                    ipend_q;
  logic                    dpend_q;
  logic                    tpend_q;
  logic [1:0]              tnum_q;
  logic                    after_exc_q;
  logic                    rst_ev;
  logic                    irq_bnd;
  logic                    irq_any;
  logic                    acc;
  exc_unit_pkg::exc_type_t acc_type;
  exc_unit_pkg::seq_state_t state_q;

  assign rst_ev = (external_reset_input_in & ~pin_q) | watchdog_overflow_in;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_q <= 1'b1;
    end else if (ce_in) begin
      pin_q <= external_reset_input_in;
    end
  end

  // a new request beats the clear of its own flag
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rpend_q <= 1'b0;
      ipend_q <= 1'b0;
      dpend_q <= 1'b0;
      tpend_q <= 1'b0;
      tnum_q  <= 2'h0;
    end else if (ce_in) begin
      rpend_q <= rst_ev | (rpend_q & ~(acc & acc_type == exc_unit_pkg::EXC_RESET));
      ipend_q <= illegal_opcode_in | (ipend_q & ~(acc & acc_type inside {exc_unit_pkg::EXC_ILLEGAL,
                 exc_unit_pkg::EXC_RESET}));
      dpend_q <= sleep_direct_in | (dpend_q & ~(acc & acc_type inside {exc_unit_pkg::EXC_DIRECT,
                 exc_unit_pkg::EXC_RESET}));
      tpend_q <= (trap_always_instruction_in & exec_state_in) |
                 (tpend_q & ~(acc & acc_type inside {exc_unit_pkg::EXC_TRAP, exc_unit_pkg::EXC_RESET}));
      if (trap_always_instruction_in && exec_state_in) begin
        tnum_q <= trap_num_in;
      end
    end
  end

  // ==========================================================
  // ranking and sequencing
  assign irq_any = nmi_in | irq_req_in | (|key_input_req_in);

  assign irq_bnd = (state_q == exc_unit_pkg::ST_RUN) & ((insn_done_in & ~insn_no_irq_in) | after_exc_q);

  always_comb begin
    acc      = 1'b0;
    acc_type = exc_unit_pkg::EXC_RESET;
    if (rpend_q) begin
      acc = 1'b1;
    end else if (state_q == exc_unit_pkg::ST_RUN) begin
      if (ipend_q) begin
        acc      = 1'b1;
        acc_type = exc_unit_pkg::EXC_ILLEGAL;
      end else if (irq_any && irq_bnd) begin
        acc      = 1'b1;
        acc_type = exc_unit_pkg::EXC_IRQ;
      end else if (dpend_q) begin
        acc      = 1'b1;
        acc_type = exc_unit_pkg::EXC_DIRECT;
      end else if (tpend_q) begin
        acc      = 1'b1;
        acc_type = exc_unit_pkg::EXC_TRAP;
      end
    end
  end

  logic        key_sel;
  logic        exc_key_q;
  logic [6:0]  vec_d;
  logic [31:0] addr_d;

  assign key_sel = ~nmi_in & ~irq_req_in & (|key_input_req_in);

  exc_vector_map u_vmap (
    .type_in     (acc_type),
    .trap_num_in (tnum_q),
    .nmi_in      (nmi_in),
    .irq_req_in  (irq_req_in),
    .irq_vec_in  (irq_vec_in),
    .key_sel_in  (key_sel),
    .key_grp_in  (~key_input_req_in[0]),
    .vts_in      (vector_table_select_out),
    .vec_out     (vec_d),
    .addr_out    (addr_d)
  );

  // reset may cut into a running sequence; nothing else may
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q        <= exc_unit_pkg::ST_RUN;
      exc_valid_out  <= 1'b0;
      exc_type_out   <= 5'h00;
      exc_vector_out <= 7'h00;
      exc_addr_out   <= 32'h00000000;
      exc_key_q      <= 1'b0;
    end else if (ce_in) begin
      if (acc) begin
        state_q        <= exc_unit_pkg::ST_EXC;
        exc_valid_out  <= 1'b1;
        exc_type_out   <= acc_type;
        exc_vector_out <= vec_d;
        exc_addr_out   <= addr_d;
        exc_key_q      <= (acc_type == exc_unit_pkg::EXC_IRQ) & key_sel;
      end else if (state_q == exc_unit_pkg::ST_EXC && exc_done_in) begin
        state_q       <= exc_unit_pkg::ST_RUN;
        exc_valid_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      after_exc_q <= 1'b0;
    end else if (ce_in) begin
      if (state_q == exc_unit_pkg::ST_EXC && exc_done_in && !acc) begin
        after_exc_q <= exc_type_out != exc_unit_pkg::EXC_RESET;
      end else if (acc || insn_done_in) begin
        after_exc_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // event status, mask and interrupt line
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stat_q <= 5'h00;
      mask_q <= 5'h00;
    end else if (ce_in) begin
      stat_q <= (stat_q & ~((wr_now && dp_addr_q == `OFS_EXC_STATUS) ? hwdata_in[4:0] : 5'h00)) |
                (acc ? acc_type : 5'h00);
      if (wr_now && dp_addr_q == `OFS_EXC_MASK) begin
        mask_q <= hwdata_in[4:0];
      end
    end
  end

  assign irq_out = |(stat_q & mask_q);

  // ==========================================================
  // checks
  sequence s_pin_rise;
    ce_in && $past(ce_in) && !$past(rst_in) && $rose(external_reset_input_in);
  endsequence

  sequence s_two_ce;
    ce_in ##1 ce_in;
  endsequence

  a_select_reset: assert property (@(posedge clk_in) rst_in |=> vector_table_select_out && register_map_select_out)
    else $error("selects not set after reset");

  a_pin_reset_start: assert property (@(posedge clk_in) disable iff (rst_in)
    s_pin_rise ##0 s_two_ce |=> exc_valid_out && exc_type_out == exc_unit_pkg::EXC_RESET)
    else $error("reset pin edge did not start reset handling");

  a_wdt_reset_start: assert property (@(posedge clk_in) disable iff (rst_in)
    (ce_in && watchdog_overflow_in) ##0 s_two_ce |=> exc_valid_out && exc_vector_out == `VEC_RESET)
    else $error("watchdog overflow did not start reset handling");

  a_rank_order: assert property (@(posedge clk_in) disable iff (rst_in)
    acc && acc_type != exc_unit_pkg::EXC_RESET |-> !rpend_q && (acc_type == exc_unit_pkg::EXC_ILLEGAL || !ipend_q))
    else $error("lower rank accepted over higher one");

  a_irq_at_boundary: assert property (@(posedge clk_in) disable iff (rst_in)
    acc && acc_type == exc_unit_pkg::EXC_IRQ |-> state_q == exc_unit_pkg::ST_RUN
      && ((insn_done_in && !insn_no_irq_in) || after_exc_q))
    else $error("interrupt accepted off a boundary");

  a_irq_quiet_ccr: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && state_q == exc_unit_pkg::ST_RUN && insn_done_in && insn_no_irq_in && !after_exc_q
      |=> exc_type_out != exc_unit_pkg::EXC_IRQ || !$rose(exc_valid_out))
    else $error("interrupt taken after ccr or control load");

  a_trap_vector: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && acc && acc_type == exc_unit_pkg::EXC_TRAP |=> exc_vector_out == `VEC_TRAP_BASE + {5'h00, $past(tnum_q)})
    else $error("trap vector number wrong");

  a_trap_unmasked: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && trap_always_instruction_in && exec_state_in |=> tpend_q || exc_type_out == exc_unit_pkg::EXC_TRAP)
    else $error("trap request lost");

  a_key_vector: assert property (@(posedge clk_in) disable iff (rst_in)
    exc_valid_out && exc_key_q |-> exc_vector_out[6:1] == (vector_table_select_out ? 6'h0F : 6'h0B))
    else $error("key group vector wrong for layout");

  a_addr_times4: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(exc_valid_out) |-> exc_addr_out == {23'h000000, exc_vector_out, 2'h0})
    else $error("fetch address not vector times four");

endmodule : exc_priority_unit

`default_nettype wire

// *** src/exc_vector_map.sv ***
// Purpose: turns the accepted exception into vector number and fetch address
// Assumes: interrupt sources ranked nmi, numbered request, key groups
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/1ns
`default_nettype none
`include "exc_unit_consts.svh"

module exc_vector_map (
  input  wire exc_unit_pkg::exc_type_t type_in,
  input  wire logic [1:0]              trap_num_in,
  input  wire logic                    nmi_in,
  input  wire logic                    irq_req_in,
  input  wire logic [6:0]              irq_vec_in,
  input  wire logic                    key_sel_in,
  input  wire logic                    key_grp_in,
  input  wire logic                    vts_in,
  output logic      [6:0]              vec_out,
  output logic      [31:0]             addr_out
);

  logic [6:0] key_base;

  assign key_base = vts_in ? `VEC_KEY_EXT : `VEC_KEY_COMPAT;

  always_comb begin
    unique case (type_in)
      exc_unit_pkg::EXC_RESET:   vec_out = `VEC_RESET;
      exc_unit_pkg::EXC_ILLEGAL: vec_out = `VEC_ILLEGAL;
      exc_unit_pkg::EXC_DIRECT:  vec_out = `VEC_DIRECT;
      exc_unit_pkg::EXC_TRAP:    vec_out = `VEC_TRAP_BASE + {5'h00, trap_num_in};
      exc_unit_pkg::EXC_IRQ: begin
        if (nmi_in) begin
          vec_out = `VEC_NMI;
        end else if (irq_req_in) begin
          vec_out = irq_vec_in;
        end else if (key_sel_in) begin
          vec_out = key_base + {6'h00, key_grp_in};
        end else begin
          vec_out = `VEC_RESET;
        end
      end
      default: vec_out = `VEC_RESET;
    endcase
  end

  assign addr_out = {23'h000000, vec_out, 2'h0};

endmodule : exc_vector_map

`default_nettype wire

// *** tb/exception_priority_vector_select_tb.sv ***
// Purpose: self-checking bench for the exception priority unit
// Assumes: one AHB-Lite master; the partner ends each handling run
// Notes:   every design input changes by non-blocking assignment at a rising edge
`timescale 1ns/1ns
`default_nettype none
`include "exc_unit_consts.svh"

module exception_priority_vector_select_tb;
  // ==========================================================
  // signals
  logic        clk_in, rst_in, ce_in, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out;
  logic        external_reset_input_in, watchdog_overflow_in, illegal_opcode_in, insn_done_in;
  logic        insn_no_irq_in, sleep_direct_in, trap_always_instruction_in, exec_state_in;
  logic        exc_done_in, nmi_in, irq_req_in, keypad_wakeup_bank_select_in, serial_bus_register_enable_in;
  logic        key_bank_lo_en_out, key_bank_hi_en_out, serial_bank_lo_en_out, serial_bank_hi_en_out;
  logic        vector_table_select_out, register_map_select_out, exc_valid_out, irq_out;
  logic [1:0]  htrans_in, trap_num_in, key_input_req_in;
  logic [2:0]  hsize_in;
  logic [3:0]  delay;
  logic [4:0]  exc_type_out;
  logic [6:0]  irq_vec_in, exc_vector_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, exc_addr_out, rd_q;
  int          n_errors, comparisons, cycles;

  assign hready_in = hreadyout_out;

  exc_priority_unit u_exc_priority_unit (
    .clk_in, .rst_in, .ce_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in,
    .hready_in, .hreadyout_out, .hresp_out, .hrdata_out, .external_reset_input_in, .watchdog_overflow_in,
    .illegal_opcode_in, .insn_done_in, .insn_no_irq_in, .sleep_direct_in, .trap_always_instruction_in,
    .trap_num_in, .exec_state_in, .exc_done_in, .nmi_in, .irq_req_in, .irq_vec_in, .key_input_req_in,
    .keypad_wakeup_bank_select_in, .serial_bus_register_enable_in, .key_bank_lo_en_out,
    .key_bank_hi_en_out, .serial_bank_lo_en_out, .serial_bank_hi_en_out, .vector_table_select_out,
    .register_map_select_out, .exc_valid_out, .exc_type_out, .exc_vector_out, .exc_addr_out, .irq_out);

  seq_partner u_seq_partner (
    .clk_in, .rst_in, .exc_valid_in(exc_valid_out), .delay_in(delay), .exc_done_out(exc_done_in));

  always #25 clk_in = ~clk_in;

  // ==========================================================
  // helpers
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // ready is judged at the falling edge, so the sampling edge is never raced
  task automatic wait_rdy();
    int n;
    n = 0;
    @(negedge clk_in);
    while (hreadyout_out !== 1'b1 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    if (hreadyout_out !== 1'b1) n_errors++;
    rd_q = hrdata_out;
    @(posedge clk_in);
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    htrans_in <= 2'h2;
    haddr_in  <= {24'h0, a};
    hwrite_in <= w;
    wait_rdy();
    htrans_in <= 2'h0;
    hwdata_in <= d;
    wait_rdy();
  endtask : bus

  // m: illegal, sleep, trap, watchdog pulses; pin and nmi levels persist
  task automatic ev(input logic [5:0] m, input logic [1:0] tn, input logic ex);
    @(posedge clk_in);
    {watchdog_overflow_in, trap_always_instruction_in, sleep_direct_in, illegal_opcode_in} <= m[3:0];
    {nmi_in, external_reset_input_in} <= m[5:4];
    trap_num_in   <= tn;
    exec_state_in <= ex;
    @(posedge clk_in);
    {watchdog_overflow_in, trap_always_instruction_in, sleep_direct_in, illegal_opcode_in} <= 4'h0;
    exec_state_in <= 1'b1;
  endtask : ev

  task automatic boundary(input logic ni, input logic nm, input logic ir, input logic [1:0] kr);
    @(posedge clk_in);
    insn_done_in <= 1'b1;
    {insn_no_irq_in, nmi_in, irq_req_in, key_input_req_in} <= {ni, nm, ir, kr};
    @(posedge clk_in);
    insn_done_in <= 1'b0;
    {insn_no_irq_in, nmi_in, irq_req_in, key_input_req_in} <= 5'h00;
  endtask : boundary

  task automatic expect_exc(input logic [4:0] t, input logic [6:0] v);
    int n;
    n = 0;
    @(negedge clk_in);
    while (exc_valid_out !== 1'b1 && n < 30) begin
      @(negedge clk_in);
      n++;
    end
    if (exc_valid_out !== 1'b1) n_errors++;
    chk("exc_type", {27'h0, exc_type_out}, {27'h0, t});
    chk("exc_vector", {25'h0, exc_vector_out}, {25'h0, v});
    chk("exc_addr", exc_addr_out, {23'h0, v, 2'h0});
    n = 0;
    while (exc_valid_out !== 1'b0 && n < 30) begin
      @(negedge clk_in);
      n++;
    end
    if (exc_valid_out !== 1'b0) n_errors++;
  endtask : expect_exc

  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge clk_in);
      if (exc_valid_out !== 1'b0) seen = 1'b1;
    end
    chk("no_exception", {31'h0, seen}, 32'h0);
  endtask : quiet

  // the ceiling is more than ten times the length of the sequence below
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      finish_test();
    end
  end

  // ==========================================================
  // test sequence
  initial begin
    {clk_in, rst_in, ce_in, hsel_in, exec_state_in, keypad_wakeup_bank_select_in} = 6'h3F;
    {hwrite_in, external_reset_input_in, watchdog_overflow_in, illegal_opcode_in} = 4'h0;
    {insn_done_in, insn_no_irq_in, sleep_direct_in, trap_always_instruction_in} = 4'h0;
    {nmi_in, irq_req_in, serial_bus_register_enable_in} = 3'h0;
    {htrans_in, trap_num_in, key_input_req_in} = 6'h00;
    clk_in     = 1'b0;
    hsize_in   = 3'h2;
    irq_vec_in = 7'h10;
    haddr_in   = 32'h0;
    hwdata_in  = 32'h0;
    delay      = 4'h0;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    bus(1'b0, `OFS_SYS_CTRL3, 32'h0);
    chk("sys_ctrl3", rd_q, 32'h60);
    chk("hresp", {31'h0, hresp_out}, 32'h0);
    chk("vec_sel", {31'h0, vector_table_select_out}, 32'h1);
    chk("banks", {28'h0, key_bank_lo_en_out, key_bank_hi_en_out, serial_bank_lo_en_out,
                  serial_bank_hi_en_out}, 32'hF);
    bus(1'b1, `OFS_SYS_CTRL3, 32'h40);
    #1;
    chk("map_sel", {31'h0, register_map_select_out}, 32'h0);
    chk("banks", {28'h0, key_bank_lo_en_out, key_bank_hi_en_out, serial_bank_lo_en_out,
                  serial_bank_hi_en_out}, 32'h6);
    @(posedge clk_in) serial_bus_register_enable_in <= 1'b1;
    #1;
    chk("banks", {28'h0, key_bank_lo_en_out, key_bank_hi_en_out, serial_bank_lo_en_out,
                  serial_bank_hi_en_out}, 32'h5);
    bus(1'b0, `OFS_SYS_CTRL3, 32'h0);
    chk("sys_ctrl3", rd_q, 32'h40);
    bus(1'b1, `OFS_SYS_CTRL3, 32'h60);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", rd_q, 32'h0);
    bus(1'b0, `OFS_EXC_MASK, 32'h0);
    chk("mask", rd_q, 32'h0);
    $display("test registers done");

    ev(6'h04, 2'h2, 1'b1);
    expect_exc(5'h10, 7'h0A);
    bus(1'b0, `OFS_EXC_STATUS, 32'h0);
    chk("status", rd_q, 32'h10);
    chk("irq_masked", {31'h0, irq_out}, 32'h0);
    bus(1'b1, `OFS_EXC_MASK, 32'h10);
    #1;
    chk("irq_set", {31'h0, irq_out}, 32'h1);
    bus(1'b1, `OFS_EXC_STATUS, 32'h10);
    #1;
    chk("irq_clear", {31'h0, irq_out}, 32'h0);
    ev(6'h04, 2'h1, 1'b0);
    quiet(8);
    $display("test trap done");

    @(posedge clk_in) delay <= 4'h6;
    ev(6'h07, 2'h3, 1'b1);
    expect_exc(5'h02, 7'h04);
    expect_exc(5'h08, 7'h06);
    expect_exc(5'h10, 7'h0B);
    ev(6'h04, 2'h0, 1'b1);
    ev(6'h08, 2'h0, 1'b1);
    // the watchdog reset cuts into the trap that is already running
    @(posedge clk_in);
    expect_exc(5'h01, 7'h00);
    $display("test ranking done");

    @(posedge clk_in) delay <= 4'h1;
    ev(6'h30, 2'h0, 1'b1);
    expect_exc(5'h01, 7'h00);
    quiet(8);
    boundary(1'b1, 1'b1, 1'b0, 2'h0);
    quiet(6);
    ev(6'h00, 2'h0, 1'b1);
    boundary(1'b0, 1'b1, 1'b0, 2'h0);
    expect_exc(5'h04, 7'h07);
    boundary(1'b0, 1'b0, 1'b1, 2'h0);
    expect_exc(5'h04, 7'h10);
    $display("test interrupts done");

    bus(1'b1, `OFS_EXC_MASK, 32'h0);
    for (int s = 1; s >= 0; s--) begin
      bus(1'b1, `OFS_SYS_CTRL3, (s != 0) ? 32'h60 : 32'h20);
      for (int k = 0; k < 2; k++) begin
        boundary(1'b0, 1'b0, 1'b0, 2'(1 << k));
        expect_exc(5'h04, ((s != 0) ? 7'h1E : 7'h16) + 7'(k));
      end
    end
    bus(1'b1, `OFS_SYS_CTRL3, 32'h60);
    $display("test key vectors done");
    finish_test();
  end
endmodule : exception_priority_vector_select_tb

`default_nettype wire

// *** tb/seq_partner.sv ***
// Purpose: sequencer stand-in that ends each exception handling run
// Assumes: exc_valid is a level held until exc_done is sampled
// Notes:   delay_in plus one valid cycles pass before the end pulse
`timescale 1ns/1ns
`default_nettype none

module seq_partner (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       exc_valid_in,
  input  wire logic [3:0] delay_in,
  output logic            exc_done_out
);
  // ==========================================================
  // handling length counter
  logic [3:0] cnt_q;

  // a preempting reset keeps valid high, so the count simply runs on
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q        <= 4'h0;
      exc_done_out <= 1'b0;
    end else begin
      exc_done_out <= exc_valid_in && !exc_done_out && (cnt_q == delay_in);
      cnt_q        <= (!exc_valid_in || exc_done_out) ? 4'h0 : cnt_q + 4'h1;
    end
  end
endmodule : seq_partner

`default_nettype wire
